// ==== dv/test_pulse_timing.sv ====
// Self-checking bench of the pulse timing block
`timescale 1ns/1ps
`default_nettype none

// Compare one value, count it, report a mismatch at once
`define CHECK(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end

module test_pulse_timing
	import pulse_timing_pkg::*;
;
	// Short finest step keeps the longest intervals affordable
	localparam int unsigned B = 4;
	// Sample levels: well above and below the threshold 0x20
	localparam logic [7:0] HI  = 8'h40;
	localparam logic [7:0] LOW = 8'h10;

	logic        hclk;          // Bus clock
	logic        hresetn;       // Async reset, active low
	logic        hsel;          // Slave select
	logic [31:0] haddr;         // Byte address
	logic [1:0]  htrans;        // Transfer kind
	logic        hwrite;        // Write strobe
	logic [2:0]  hsize;         // Always a word
	logic [31:0] hwdata;        // Write data
	logic        hreadyout;     // Slave ready, also the bus ready
	logic        hresp;         // Response
	logic [31:0] hrdata;        // Read data
	logic        accel_valid;   // Sample strobe
	logic [7:0]  accel_mag;     // Sample magnitude
	logic        single_pulse;  // First pulse qualified
	logic        double_pulse;  // Second pulse qualified
	int          miscompares;   // Mismatches seen
	int          cmp_count;     // Comparisons made

	// Step table: config byte, filter bit, step in 0.625 ms units
	logic [7:0]  cfg_tab[7]  = '{8'h01, 8'h01, 8'hf1, 8'hf1, 8'hf9, 8'ha9, 8'h81};
	logic        filt_tab[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	int unsigned unit_tab[7] = '{1, 2, 4, 1, 64, 128, 8};

	pulse_timing #(
		.BASE_STEP_CYCLES(B)
	) i_dut (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hwdata      (hwdata),
		.hready      (hreadyout),
		.hreadyout   (hreadyout),
		.hresp       (hresp),
		.hrdata      (hrdata),
		.accel_valid (accel_valid),
		.accel_mag   (accel_mag),
		.single_pulse(single_pulse),
		.double_pulse(double_pulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock, 5 ns period
	always #2.5 hclk = ~hclk;

	// Verdict and the end of the run
	task automatic print_verdict;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Wait for ready at a rising edge, bounded
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 20) begin
			n++;
			@(posedge hclk);
		end
		if (n == 20) begin
			miscompares++;
			print_verdict();
		end
	endtask

	// Single word write; address phase held until taken
	task automatic reg_write(input logic [7:0] idx, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
	endtask

	// Single word read; data taken at the edge that ends the data phase
	task automatic reg_check(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b0;
		haddr  <= {22'h0, idx, 2'b00};
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		wait_ready();
		`CHECK(nm, exp, hrdata)
		`CHECK("hresp", 1'b0, hresp)
	endtask

	// One sample strobe, one cycle wide
	task automatic sample(input logic [7:0] m);
		accel_valid <= 1'b1;
		accel_mag   <= m;
		@(posedge hclk);
		accel_valid <= 1'b0;
	endtask

	// Rise sample, len idle cycles, fall sample; returns at the edge that
	// samples the one-cycle result strobe, before it drops again
	task automatic pulse(input logic [7:0] hi, input int len);
		sample(hi);
		repeat (len) @(posedge hclk);
		sample(LOW);
		@(posedge hclk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Hang guard: a run this long means a stuck wait
	initial begin
		repeat (100000) @(posedge hclk);
		miscompares++;
		print_verdict();
	end

	// Main sequence
	initial begin
		hclk        = 1'b0;
		hresetn     = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'b00;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		accel_valid = 1'b0;
		accel_mag   = 8'h00;
		miscompares = 0;
		cmp_count   = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;

		// Timer registers: reset value, full width, unmapped index reads zero
		reg_check("limit_rst", IDX_DURLIM, 32'h0);
		reg_check("lat_rst", IDX_LATENCY, 32'h0);
		reg_check("span_rst", IDX_SPAN, 32'h0);
		reg_write(IDX_DURLIM, 32'h0000_00ff);
		reg_write(IDX_LATENCY, 32'h0000_00a5);
		reg_write(IDX_SPAN, 32'h0000_005a);
		reg_write(8'h50, 32'h0000_0077);
		reg_check("limit_max", IDX_DURLIM, 32'h0000_00ff);
		reg_check("lat_rw", IDX_LATENCY, 32'h0000_00a5);
		reg_check("span_rw", IDX_SPAN, 32'h0000_005a);
		reg_check("unmapped", 8'h50, 32'h0);

		// Threshold is strict: equal does not start a pulse
		reg_write(IDX_THRESH, 32'h0000_0020);
		reg_check("thresh_rw", IDX_THRESH, 32'h0000_0020);
		reg_write(IDX_FILTER, 32'h0);
		reg_write(IDX_CONFIG, 32'h0000_0001);
		// Latency is set even though only single pulses are wanted here
		reg_write(IDX_LATENCY, 32'h0000_0001);
		reg_write(IDX_DURLIM, 32'h0);
		pulse(HI, 2);
		`CHECK("zero_limit", 1'b0, single_pulse)
		reg_write(IDX_DURLIM, 32'h0000_0004);
		pulse(8'h20, 2);
		`CHECK("at_thresh", 1'b0, single_pulse)
		repeat (12) @(posedge hclk);
		pulse(8'h21, 2);
		`CHECK("over_thresh", 1'b1, single_pulse)
		repeat (12) @(posedge hclk);

		// Duration step per filter, mode and rate: 2 steps pass, 5 fail at limit 4
		for (int i = 0; i < 7; i++) begin
			reg_write(IDX_FILTER, {31'h0, filt_tab[i]});
			reg_write(IDX_CONFIG, {24'h0, cfg_tab[i]});
			pulse(HI, 2 * B * unit_tab[i]);
			`CHECK("step_pass", 1'b1, single_pulse)
			repeat (8 * B * unit_tab[i]) @(posedge hclk);
			pulse(HI, 5 * B * unit_tab[i]);
			`CHECK("step_fail", 1'b0, single_pulse)
			repeat (4 * B * unit_tab[i]) @(posedge hclk);
		end

		// Double mode: latency 3 x 8 cycles, span 3 x 8 cycles, limit 10 x 4
		reg_write(IDX_FILTER, 32'h0);
		reg_write(IDX_CONFIG, 32'h0000_0003);
		reg_write(IDX_DURLIM, 32'h0000_000a);
		reg_write(IDX_LATENCY, 32'h0000_0003);
		reg_write(IDX_SPAN, 32'h0000_0003);
		pulse(HI, 4);
		`CHECK("first", 1'b1, single_pulse)
		pulse(HI, 2);
		`CHECK("lat_sgl", 1'b0, single_pulse)
		`CHECK("lat_dbl", 1'b0, double_pulse)
		repeat (20) @(posedge hclk);
		// Second pulse starts inside the window and ends after it closes
		pulse(HI, 30);
		`CHECK("second", 1'b1, double_pulse)
		// Both sticky flags set, phase back to idle; write one clears them
		reg_check("status_seen", IDX_STATUS, 32'h0000_0030);
		reg_write(IDX_STATUS, 32'h0000_0030);
		reg_check("status_clr", IDX_STATUS, 32'h0);
		repeat (4) @(posedge hclk);

		// Second pulse after the window: seen as a new first pulse
		pulse(HI, 4);
		`CHECK("first_b", 1'b1, single_pulse)
		repeat (60) @(posedge hclk);
		pulse(HI, 4);
		`CHECK("late_dbl", 1'b0, double_pulse)
		`CHECK("late_sgl", 1'b1, single_pulse)
		repeat (60) @(posedge hclk);

		// Abort: a whole pulse inside latency suspends the double
		reg_write(IDX_CONFIG, 32'h0000_0007);
		pulse(HI, 4);
		`CHECK("first_c", 1'b1, single_pulse)
		pulse(HI, 2);
		// Still in latency, single seen, abort flag raised
		reg_check("abort_flag", IDX_STATUS, 32'h0000_0052);
		repeat (20) @(posedge hclk);
		pulse(HI, 4);
		`CHECK("abort_dbl", 1'b0, double_pulse)
		`CHECK("abort_sgl", 1'b1, single_pulse)
		repeat (60) @(posedge hclk);
		print_verdict();
	end

endmodule

`undef CHECK
`default_nettype wire

// ==== logic/pulse_timing.sv ====
// Pulse duration, latency and second-pulse window timing with AHB-Lite registers
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pulse_timing
	import pulse_timing_pkg::*;
#(
	parameter int unsigned BASE_STEP_CYCLES = BASE_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        accel_valid,
	input  wire logic [7:0]  accel_mag,
	output logic             single_pulse,
	output logic             double_pulse
);

	////////////////////////////////////////////////////////////////////////////
	// State of the whole block
	typedef struct packed {
		logic [7:0]  dur_lim;    // Pulse duration limit
		logic [7:0]  lat;        // Pulse latency
		logic [7:0]  span;       // Second pulse span
		logic [6:0]  thr;        // Pulse threshold
		logic        filt;       // Pulse lowpass enable
		logic [7:0]  cfg;        // Enable, double, abort, mode, rate
		phase_e      st;         // Detector phase
		logic [7:0]  cnt;        // Interval step count
		logic        above;      // Last sample above threshold
		logic        lat_rise;   // A pulse started inside latency
		logic        abort_hit;  // Double detection suspended
		logic        seen_s;     // Sticky single seen
		logic        seen_d;     // Sticky double seen
		logic        sgl;        // Single pulse strobe
		logic        dbl;        // Double pulse strobe
		logic        wr_pend;    // Write data phase pending
		logic        rd_pend;    // Read data phase pending
		logic        hit_ok;     // Upper address bits were zero
		logic [7:0]  idx;        // Captured word index
		logic        rdy;        // Bus ready
		logic        resp;       // Bus response, always OKAY
		logic [31:0] rdata;      // Read data
	} core_s;

	core_s       q;
	core_s       d;
	step_cfg_s   tcfg;       // Step selection for the divider
	logic        dur_tick;   // Duration step tick
	logic        wide_tick;  // Latency and window step tick
	logic        en;         // Detector enabled
	logic        dbl_en;     // Double detection wanted
	logic        abort_en;   // Double abort bit
	logic        hot;        // Current sample above threshold
	logic        rise;       // Pulse start
	logic        fall;       // Pulse end
	logic        take;       // Address phase accepted
	logic        clr_s;      // Software clears single flag
	logic        clr_d;      // Software clears double flag
	logic [31:0] rmux;       // Read value of the captured index
	logic [7:0]  wbyte;      // Low write data byte

	assign en       = q.cfg[CFG_EN_BIT];
	assign dbl_en   = q.cfg[CFG_DBL_BIT];
	assign abort_en = q.cfg[CFG_ABT_BIT];
	assign wbyte    = hwdata[7:0];

	// Mode and rate fields feed the divider
	always_comb begin
		tcfg.pulse_lowpass_enable = q.filt;
		tcfg.mode                 = oversample_e'(q.cfg[CFG_MODE_LSB +: 2]);
		tcfg.output_data_rate     = q.cfg[CFG_DR_LSB +: 3];
	end

	step_tick_gen #(
		.BASE (BASE_STEP_CYCLES)
	) u_tick (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.cfg       (tcfg),
		.dur_tick  (dur_tick),
		.wide_tick (wide_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sample edges; samples come from logic on this clock
	assign hot  = accel_mag > {1'b0, q.thr};
	assign rise = accel_valid && hot && !q.above;
	assign fall = accel_valid && !hot && q.above;

	// Bus decode
	assign take  = hsel && htrans[1] && hready;
	assign clr_s = q.wr_pend && q.hit_ok && q.idx == IDX_STATUS && hwdata[ST_SGL_BIT];
	assign clr_d = q.wr_pend && q.hit_ok && q.idx == IDX_STATUS && hwdata[ST_DBL_BIT];

	// Read multiplexer; unmapped indices read zero
	always_comb begin
		rmux = 32'h00000000;
		if (q.hit_ok) begin
			case (q.idx)
				IDX_FILTER:  rmux[FILT_BIT] = q.filt;
				IDX_THRESH:  rmux[6:0] = q.thr;
				IDX_DURLIM:  rmux[7:0] = q.dur_lim;
				IDX_LATENCY: rmux[7:0] = q.lat;
				IDX_SPAN:    rmux[7:0] = q.span;
				IDX_CONFIG:  rmux[7:0] = q.cfg;
				IDX_STATUS: begin
					rmux[2:0]        = q.st;
					rmux[ST_SGL_BIT] = q.seen_s;
					rmux[ST_DBL_BIT] = q.seen_d;
					rmux[ST_ABT_BIT] = q.abort_hit;
				end
				default: rmux = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, then the detector
	always_comb begin
		d      = q;
		d.sgl  = 1'b0;
		d.dbl  = 1'b0;
		d.resp = 1'b0;

		// Write data phase; writes never stall
		d.wr_pend = 1'b0;
		if (q.wr_pend && q.hit_ok) begin
			case (q.idx)
				IDX_FILTER:  d.filt = hwdata[FILT_BIT];
				IDX_THRESH:  d.thr = hwdata[6:0];
				IDX_DURLIM:  d.dur_lim = wbyte;
				IDX_LATENCY: d.lat = wbyte;
				IDX_SPAN:    d.span = wbyte;
				IDX_CONFIG:  d.cfg = wbyte;
				default:     d.cfg = q.cfg;
			endcase
		end

		// Read takes one wait state so a write just before it is seen
		if (q.rd_pend) begin
			d.rdata   = rmux;
			d.rdy     = 1'b1;
			d.rd_pend = 1'b0;
		end

		// Address phase
		if (take) begin
			d.idx     = haddr[9:2];
			d.hit_ok  = (haddr[31:10] == 22'h000000);
			d.wr_pend = hwrite;
			d.rd_pend = !hwrite;
			d.rdy     = hwrite;
		end

		// Sample history
		if (accel_valid) begin
			d.above = hot;
		end

		// Interval detector
		case (q.st)
			PH_IDLE: begin
				if (rise) begin
					d.st  = PH_FIRST;
					d.cnt = 8'h00;
				end
			end
			PH_FIRST, PH_SECOND: begin
				// Count duration steps while above threshold
				if (dur_tick && q.cnt != CNT_MAX) begin
					d.cnt = q.cnt + 8'h01;
				end
				if (fall) begin
					d.cnt = 8'h00;
					// Ended before the limit ran out; a zero limit never qualifies
					if (q.cnt < q.dur_lim) begin
						if (q.st == PH_FIRST) begin
							d.sgl       = 1'b1;
							d.st        = PH_LATENCY;
							d.lat_rise  = 1'b0;
							d.abort_hit = 1'b0;
						end else begin
							d.dbl = 1'b1;
							d.st  = PH_IDLE;
						end
					end else begin
						d.st = PH_IDLE;
					end
				end
			end
			PH_LATENCY: begin
				// Pulses here are ignored, only watched for abort
				if (wide_tick && q.cnt != CNT_MAX) begin
					d.cnt = q.cnt + 8'h01;
				end
				if (rise) begin
					d.lat_rise = 1'b1;
				end
				if (fall && q.lat_rise && abort_en) begin
					d.abort_hit = 1'b1;
				end
				// Zero latency expires at once
				if (q.cnt >= q.lat) begin
					d.cnt = 8'h00;
					if (dbl_en && q.span != 8'h00 && !q.abort_hit) begin
						d.st = PH_WINDOW;
					end else begin
						d.st = PH_IDLE;
					end
				end
			end
			PH_WINDOW: begin
				if (wide_tick && q.cnt != CNT_MAX) begin
					d.cnt = q.cnt + 8'h01;
				end
				// Start must land before the window expires
				if (rise && q.cnt < q.span) begin
					d.st  = PH_SECOND;
					d.cnt = 8'h00;
				end else if (q.cnt >= q.span) begin
					d.st  = PH_IDLE;
					d.cnt = 8'h00;
				end
			end
			default: begin
				d.st = PH_IDLE;
			end
		endcase

		// Disabled detector parks idle
		if (!en) begin
			d.st  = PH_IDLE;
			d.cnt = 8'h00;
		end

		// Sticky flags: a set in the clearing cycle wins
		d.seen_s = (q.seen_s && !clr_s) || d.sgl;
		d.seen_d = (q.seen_d && !clr_d) || d.dbl;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; timer registers come out of reset at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q         <= '0;
			q.dur_lim <= RST_TIMER;
			q.lat     <= RST_TIMER;
			q.span    <= RST_TIMER;
			q.thr     <= RST_THRESH;
			q.cfg     <= RST_CONFIG;
			q.st      <= PH_IDLE;
			q.rdy     <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign hreadyout    = q.rdy;
	assign hresp        = q.resp;
	assign hrdata       = q.rdata;
	assign single_pulse = q.sgl;
	assign double_pulse = q.dbl;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	limit_met_a: assert property (
		single_pulse |-> $past(q.st) == PH_FIRST && $past(q.cnt) < $past(q.dur_lim))
		else $error("single pulse without meeting the limit");

	zero_limit_a: assert property (
		q.st == PH_FIRST && q.dur_lim == 8'h00 |=> !single_pulse)
		else $error("pulse qualified with zero limit");

	latency_entry_a: assert property (
		single_pulse |-> q.st == PH_LATENCY || !en)
		else $error("first pulse did not start latency");

	latency_quiet_a: assert property (
		q.st == PH_LATENCY ##1 q.st == PH_LATENCY |-> !single_pulse && !double_pulse)
		else $error("event reported during latency");

	latency_hold_a: assert property (
		q.st == PH_LATENCY && q.cnt < q.lat && en |=> q.st == PH_LATENCY)
		else $error("latency left before its count");

	window_gate_a: assert property (
		q.st == PH_LATENCY ##1 q.st == PH_WINDOW |-> $past(q.span) != 8'h00 && $past(dbl_en))
		else $error("window opened without double mode");

	window_close_a: assert property (
		q.st == PH_WINDOW && q.cnt >= q.span |=> q.st == PH_IDLE)
		else $error("window stayed open past its span");

	abort_block_a: assert property (
		q.st == PH_LATENCY && q.abort_hit |=> q.st != PH_WINDOW)
		else $error("aborted detection opened a window");

	double_source_a: assert property (
		double_pulse |-> $past(q.st) == PH_SECOND && $past(q.cnt) < $past(q.dur_lim))
		else $error("double pulse not from a valid second pulse");

	latency_write_a: assert property (
		q.wr_pend && q.hit_ok && q.idx == IDX_LATENCY |=> q.lat == $past(wbyte))
		else $error("latency register not written");

	read_wait_a: assert property (
		take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	single_seen_c: cover property (single_pulse);
	double_seen_c: cover property (double_pulse);
	abort_seen_c: cover property (q.st == PH_LATENCY && q.abort_hit);
	window_miss_c: cover property (q.st == PH_WINDOW ##1 q.st == PH_IDLE);

endmodule
`default_nettype wire

// ==== logic/pulse_timing_pkg.sv ====
// Shared constants, types and step tables of the pulse timing block
package pulse_timing_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	// Bus clock period
	localparam int unsigned CLK_PERIOD_NS = 5;
	// Finest time step of any interval, 0.625 ms
	localparam int unsigned STEP_BASE_NS  = 625000;
	// Clock cycles in one finest step
	localparam int unsigned BASE_CYCLES   = STEP_BASE_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_FILTER  = 8'h0f;
	localparam logic [7:0] IDX_THRESH  = 8'h23;
	localparam logic [7:0] IDX_DURLIM  = 8'h26;
	localparam logic [7:0] IDX_LATENCY = 8'h27;
	localparam logic [7:0] IDX_SPAN    = 8'h28;
	localparam logic [7:0] IDX_CONFIG  = 8'h30;
	localparam logic [7:0] IDX_STATUS  = 8'h31;

	// Field positions
	localparam int unsigned FILT_BIT     = 0;
	localparam int unsigned CFG_EN_BIT   = 0;
	localparam int unsigned CFG_DBL_BIT  = 1;
	localparam int unsigned CFG_ABT_BIT  = 2;
	localparam int unsigned CFG_MODE_LSB = 3;
	localparam int unsigned CFG_DR_LSB   = 5;
	localparam int unsigned ST_SGL_BIT   = 4;
	localparam int unsigned ST_DBL_BIT   = 5;
	localparam int unsigned ST_ABT_BIT   = 6;

	// Values after reset
	localparam logic [7:0] RST_TIMER  = 8'h00;
	localparam logic [6:0] RST_THRESH = 7'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	// Interval counters stop at the largest setting, 255 steps
	localparam logic [7:0] CNT_MAX    = 8'hff;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		OS_NORMAL,
		OS_LOW_POWER_LOW_NOISE,
		OS_HIGH_RESOLUTION,
		OS_LOW_POWER
	} oversample_e;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_FIRST,
		PH_LATENCY,
		PH_WINDOW,
		PH_SECOND
	} phase_e;

	// What selects the step length
	typedef struct packed {
		logic        pulse_lowpass_enable;
		oversample_e mode;
		logic [2:0]  output_data_rate;
	} step_cfg_s;

	// Duration step as a power of two of 0.625 ms; nibble n is data rate n.
	// Row order from the top: low power, high res, low noise, normal.
	localparam logic [3:0][31:0] EXP_LPF_OFF = {
		32'h66643210, 32'h00000000, 32'h55532100, 32'h33332100
	};
	localparam logic [3:0][31:0] EXP_LPF_ON = {
		32'h88754321, 32'h22222221, 32'h77754321, 32'h55554321
	};

	// Duration step exponent; latency and window use one more
	function automatic logic [3:0] step_exp(input step_cfg_s c);
		logic [7:0][3:0] row;
		row = c.pulse_lowpass_enable ? EXP_LPF_ON[c.mode] : EXP_LPF_OFF[c.mode];
		return row[c.output_data_rate];
	endfunction

endpackage

// ==== logic/step_tick_gen.sv ====
// Time-step tick divider for the pulse interval counters
`timescale 1ns/1ps
`default_nettype none

module step_tick_gen
	import pulse_timing_pkg::*;
#(
	parameter int unsigned BASE = BASE_CYCLES
) (
	input  wire logic      hclk,
	input  wire logic      hresetn,
	input  wire step_cfg_s cfg,
	output logic           dur_tick,
	output logic           wide_tick
);

	localparam int unsigned PW = $clog2(BASE + 1);

	// Prescaler, octave counter and the two tick flops
	typedef struct packed {
		logic [PW-1:0] pre;
		logic [9:0]    oct;
		logic          dur;
		logic          wide;
	} tick_s;

	tick_s      q;
	tick_s      d;
	logic       base;   // One finest step elapsed
	logic [3:0] e;      // Duration step exponent
	logic [9:0] mask_d; // Octave bits for a duration step
	logic [9:0] mask_w; // Octave bits for a latency step

	////////////////////////////////////////////////////////////////////////////
	// Free-running divider; steps are not phase aligned to interval starts,
	// which costs up to one step of slack but saves a divider per counter
	always_comb begin
		d      = q;
		base   = (q.pre == PW'(BASE - 1));
		e      = step_exp(cfg);
		mask_d = (10'h001 << e) - 10'h001;
		mask_w = (10'h002 << e) - 10'h001;
		d.pre  = base ? '0 : q.pre + PW'(1);
		d.oct  = base ? q.oct + 10'h001 : q.oct;
		d.dur  = base && ((q.oct & mask_d) == mask_d);
		d.wide = base && ((q.oct & mask_w) == mask_w);
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dur_tick  = q.dur;
	assign wide_tick = q.wide;

	////////////////////////////////////////////////////////////////////////////
	// A latency step is always a whole number of duration steps
	wide_nests_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wide_tick |-> dur_tick)
		else $error("latency tick without duration tick");

endmodule
`default_nettype wire
